/* shared/rad_pkg.sv */
/*
 region access decoder package: access sizes, regions, address map, states.
 assumes a 32-bit byte address where the upper byte is 00 or ff as printed.
*/
package rad_pkg;

    typedef enum logic [1:0] {
        RAD_SZ_BYTE = 2'h0,
        RAD_SZ_WORD = 2'h1,
        RAD_SZ_LONG = 2'h2
    } rad_size_e;

    typedef enum logic [2:0] {
        RAD_RG_NONE  = 3'h0,
        RAD_RG_FLASH = 3'h1,
        RAD_RG_ROM   = 3'h2,
        RAD_RG_RAM   = 3'h3,
        RAD_RG_RIO   = 3'h4,
        RAD_RG_P8    = 3'h5,
        RAD_RG_P16   = 3'h6,
        RAD_RG_INTC  = 3'h7
    } rad_region_e;

    localparam logic [31:0] RAD_FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] RAD_FLASH_LAST = 32'h0000_3fff;
    localparam logic [31:0] RAD_ROM_BASE   = 32'h0030_0000;
    localparam logic [31:0] RAD_ROM_LAST   = 32'h0030_0fff;
    localparam logic [31:0] RAD_RAM_BASE   = 32'h0080_0000;
    localparam logic [31:0] RAD_RAM_LAST   = 32'h0080_07ff;
    localparam logic [31:0] RAD_RIO_BASE   = 32'h00c0_0000;
    localparam logic [31:0] RAD_RIO_LAST   = 32'h00c0_000f;
    localparam logic [31:0] RAD_P8_BASE    = 32'hffff_8000;
    localparam logic [31:0] RAD_P16_BASE   = 32'hffff_ec00;
    localparam logic [31:0] RAD_INTC_BASE  = 32'hffff_ffc0;
    localparam logic [31:0] RAD_NV_FIRST   = 32'h0000_3ffc;
    localparam logic [31:0] RAD_NV_BOOT    = 32'h0000_3ffe;
    localparam logic [31:0] RAD_NV_SEC     = 32'h0000_3fff;
    localparam logic [7:0]  RAD_NV_RESET   = 8'hff;

    typedef enum logic [1:0] {
        RAD_ST_IDLE = 2'h0,
        RAD_ST_WAIT = 2'h1,
        RAD_ST_RESP = 2'h3
    } rad_state_e;

endpackage

/* shared/rad_if.sv */
/*
 system bus between the cpu end and the region bridge.
 assumes both ends share one clock; the testbench supplies it to both modules.
*/
`timescale 1ns/1ps
interface rad_if;
    logic        req;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ack;
    logic        err;

    modport cpu (output req, output write, output size, output addr, output wdata,
                 input rdata, input ack, input err);
    modport brg (input req, input write, input size, input addr, input wdata,
                 output rdata, output ack, output err);
endinterface

/* hdl/rad_bridge.sv */
/*
 region bridge: decodes system bus accesses, checks permissions, serializes
 wide accesses onto narrow peripheral buses and tracks the nonvolatile bytes.
 assumes the target port is on REF_CLK and acks at least one cycle after a request.
*/
// Function
// - big-endian byte order, lowest address most significant
// - multi-byte operand addressed by its first byte
// - forbidden access ends bus cycle with error
// - per-region read and write width permissions
// - 8-bit peripherals get consecutive byte accesses
// - 16-bit peripherals get longs as two words
// - master keeps peripheral accesses aligned
// - top 64 bytes go to interrupt controller
// - interrupt controller space is byte only
// - documented zero controller bits read as zero
// - software writes zero to reserved controller bits
// - four nonvolatile bytes end flash
// - last byte security, previous byte boot options
// - nonvolatile bytes changed only by flash programming
// - rapid io window routed to rapid io module
// - unimplemented access: reset or address exception
`timescale 1ns/1ps
module rad_bridge #(
    parameter logic [7:0] INTC_ZERO_MASK = 8'h00
) (
    input  wire logic               REF_CLK,
    input  wire logic               SYS_RST,
    rad_if.brg                      BUS,
    input  wire logic               ADDRESS_RESET_DISABLE,
    output logic                    TGT_REQ,
    output rad_pkg::rad_region_e    TGT_SEL,
    output logic [31:0]             TGT_ADDR,
    output logic [1:0]              TGT_SIZE,
    output logic                    TGT_WR,
    output logic [31:0]             TGT_WDATA,
    input  wire logic               TGT_ACK,
    input  wire logic [31:0]        TGT_RDATA,
    output logic                    ILLEGAL_ADDR_RST,
    output logic                    ADDR_ERR_EXC,
    output logic [7:0]              NV_SECURITY,
    output logic [7:0]              NV_BOOT
);

    ////////////////////////////////////////////////////////////////////////////
    // decode of the incoming request

    rad_pkg::rad_region_e region;
    logic                 allowed;
    logic [2:0]           beats;
    logic [1:0]           beat_size;
    logic [31:0]          wd_left;

    always_comb begin
        region = rad_pkg::RAD_RG_NONE;
        if (BUS.addr <= rad_pkg::RAD_FLASH_LAST) begin
            region = rad_pkg::RAD_RG_FLASH;
        end else if (BUS.addr >= rad_pkg::RAD_ROM_BASE && BUS.addr <= rad_pkg::RAD_ROM_LAST) begin
            region = rad_pkg::RAD_RG_ROM;
        end else if (BUS.addr >= rad_pkg::RAD_RAM_BASE && BUS.addr <= rad_pkg::RAD_RAM_LAST) begin
            region = rad_pkg::RAD_RG_RAM;
        end else if (BUS.addr >= rad_pkg::RAD_RIO_BASE && BUS.addr <= rad_pkg::RAD_RIO_LAST) begin
            region = rad_pkg::RAD_RG_RIO;
        end else if (BUS.addr >= rad_pkg::RAD_INTC_BASE) begin
            region = rad_pkg::RAD_RG_INTC;
        end else if (BUS.addr >= rad_pkg::RAD_P16_BASE) begin
            region = rad_pkg::RAD_RG_P16;
        end else if (BUS.addr >= rad_pkg::RAD_P8_BASE) begin
            region = rad_pkg::RAD_RG_P8;
        end
    end

    always_comb begin
        allowed = 1'b0;
        if (BUS.size != 2'h3) begin
            unique case (region)
                rad_pkg::RAD_RG_FLASH: allowed = !BUS.write ||
                                                 BUS.size == rad_pkg::RAD_SZ_LONG;
                rad_pkg::RAD_RG_ROM:   allowed = !BUS.write;
                rad_pkg::RAD_RG_RAM,
                rad_pkg::RAD_RG_RIO,
                rad_pkg::RAD_RG_P8:    allowed = 1'b1;
                rad_pkg::RAD_RG_P16:   allowed = BUS.size != rad_pkg::RAD_SZ_BYTE;
                rad_pkg::RAD_RG_INTC:  allowed = BUS.size == rad_pkg::RAD_SZ_BYTE;
                rad_pkg::RAD_RG_NONE:  allowed = 1'b0;
            endcase
        end
    end

    // the operand is right-justified on the bus; left-justify it so every beat
    // takes the most significant remaining part first
    always_comb begin
        beats     = 3'h1;
        beat_size = BUS.size;
        wd_left   = BUS.wdata;
        if (BUS.size == rad_pkg::RAD_SZ_BYTE) begin
            wd_left = {BUS.wdata[7:0], 24'h000000};
        end else if (BUS.size == rad_pkg::RAD_SZ_WORD) begin
            wd_left = {BUS.wdata[15:0], 16'h0000};
        end
        if (region == rad_pkg::RAD_RG_P8) begin
            beat_size = rad_pkg::RAD_SZ_BYTE;
            beats     = (BUS.size == rad_pkg::RAD_SZ_LONG) ? 3'h4 :
                        (BUS.size == rad_pkg::RAD_SZ_WORD) ? 3'h2 : 3'h1;
        end else if (region == rad_pkg::RAD_RG_P16 && BUS.size == rad_pkg::RAD_SZ_LONG) begin
            beat_size = rad_pkg::RAD_SZ_WORD;
            beats     = 3'h2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer state

    rad_pkg::rad_state_e state_q;
    logic [2:0]          left_q;
    logic [31:0]         shift_q;
    logic [31:0]         acc_q;
    logic [31:0]         op_addr_q;
    logic [1:0]          op_size_q;
    logic                serial_q;
    logic                beat_done;
    logic [31:0]         beat_rd;
    logic [31:0]         acc_d;

    assign beat_done = state_q == rad_pkg::RAD_ST_WAIT && TGT_ACK && !TGT_REQ;

    // documented zero bits of the controller never leak a stray one
    always_comb begin
        beat_rd = TGT_RDATA;
        if (TGT_SEL == rad_pkg::RAD_RG_INTC) begin
            beat_rd = {24'h000000, TGT_RDATA[7:0] & ~INTC_ZERO_MASK};
        end
    end

    // earlier beats carry the more significant part of the operand
    always_comb begin
        acc_d = beat_rd;
        if (serial_q) begin
            acc_d = (TGT_SIZE == rad_pkg::RAD_SZ_BYTE) ?
                    {acc_q[23:0], beat_rd[7:0]} : {acc_q[15:0], beat_rd[15:0]};
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state_q <= rad_pkg::RAD_ST_IDLE;
        end else begin
            unique case (state_q)
                rad_pkg::RAD_ST_IDLE: begin
                    if (BUS.req) begin
                        state_q <= allowed ? rad_pkg::RAD_ST_WAIT : rad_pkg::RAD_ST_RESP;
                    end
                end
                rad_pkg::RAD_ST_WAIT: begin
                    if (beat_done && left_q == 3'h1) begin
                        state_q <= rad_pkg::RAD_ST_RESP;
                    end
                end
                rad_pkg::RAD_ST_RESP: state_q <= rad_pkg::RAD_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // target port, one request pulse per beat

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            TGT_REQ   <= 1'b0;
            TGT_SEL   <= rad_pkg::RAD_RG_NONE;
            TGT_ADDR  <= 32'h00000000;
            TGT_SIZE  <= 2'h0;
            TGT_WR    <= 1'b0;
            TGT_WDATA <= 32'h00000000;
            left_q    <= 3'h0;
            shift_q   <= 32'h00000000;
            serial_q  <= 1'b0;
            op_addr_q <= 32'h00000000;
            op_size_q <= 2'h0;
        end else begin
            TGT_REQ <= 1'b0;
            if (state_q == rad_pkg::RAD_ST_IDLE && BUS.req && allowed) begin
                TGT_REQ   <= 1'b1;
                TGT_SEL   <= region;
                TGT_ADDR  <= BUS.addr;
                TGT_SIZE  <= beat_size;
                TGT_WR    <= BUS.write;
                left_q    <= beats;
                serial_q  <= beats != 3'h1;
                op_addr_q <= BUS.addr;
                op_size_q <= BUS.size;
                shift_q   <= (beat_size == rad_pkg::RAD_SZ_BYTE) ? {wd_left[23:0], 8'h00} :
                             {wd_left[15:0], 16'h0000};
                TGT_WDATA <= (beats == 3'h1) ? BUS.wdata :
                             (beat_size == rad_pkg::RAD_SZ_BYTE) ?
                             {24'h000000, wd_left[31:24]} : {16'h0000, wd_left[31:16]};
            end else if (beat_done && left_q != 3'h1) begin
                TGT_REQ <= 1'b1;
                left_q  <= left_q - 3'h1;
                if (TGT_SIZE == rad_pkg::RAD_SZ_BYTE) begin
                    TGT_ADDR  <= TGT_ADDR + 32'h00000001;
                    TGT_WDATA <= {24'h000000, shift_q[31:24]};
                    shift_q   <= {shift_q[23:0], 8'h00};
                end else begin
                    TGT_ADDR  <= TGT_ADDR + 32'h00000002;
                    TGT_WDATA <= {16'h0000, shift_q[31:16]};
                    shift_q   <= {shift_q[15:0], 16'h0000};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer to the cpu and the unimplemented-address events

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            BUS.ack          <= 1'b0;
            BUS.err          <= 1'b0;
            BUS.rdata        <= 32'h00000000;
            acc_q            <= 32'h00000000;
            ILLEGAL_ADDR_RST <= 1'b0;
            ADDR_ERR_EXC     <= 1'b0;
        end else begin
            BUS.ack          <= 1'b0;
            BUS.err          <= 1'b0;
            ILLEGAL_ADDR_RST <= 1'b0;
            ADDR_ERR_EXC     <= 1'b0;
            if (state_q == rad_pkg::RAD_ST_IDLE && BUS.req && !allowed) begin
                BUS.err <= 1'b1;
                if (region == rad_pkg::RAD_RG_NONE) begin
                    ILLEGAL_ADDR_RST <= !ADDRESS_RESET_DISABLE;
                    ADDR_ERR_EXC     <= ADDRESS_RESET_DISABLE;
                end
            end
            if (beat_done) begin
                acc_q <= acc_d;
                if (left_q == 3'h1) begin
                    BUS.ack   <= 1'b1;
                    BUS.rdata <= TGT_WR ? 32'h00000000 : (op_size_q == rad_pkg::RAD_SZ_WORD) ?
                                 {16'h0000, acc_d[15:0]} : acc_d;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // nonvolatile shadows follow flash reads; reset as erased flash

    logic [2:0] nbytes;

    assign nbytes = (op_size_q == rad_pkg::RAD_SZ_LONG) ? 3'h4 :
                    (op_size_q == rad_pkg::RAD_SZ_WORD) ? 3'h2 : 3'h1;

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            NV_SECURITY <= rad_pkg::RAD_NV_RESET;
            NV_BOOT     <= rad_pkg::RAD_NV_RESET;
        end else if (beat_done && left_q == 3'h1 && !TGT_WR && TGT_SEL == rad_pkg::RAD_RG_FLASH &&
                     op_addr_q >= rad_pkg::RAD_NV_FIRST - 32'h00000003) begin
            for (int k = 0; k < 4; k++) begin
                if (3'(k) < nbytes) begin
                    if (op_addr_q + 32'(k) == rad_pkg::RAD_NV_SEC) begin
                        NV_SECURITY <= 8'(acc_d >> (8 * (32'(nbytes) - 1 - k)));
                    end
                    if (op_addr_q + 32'(k) == rad_pkg::RAD_NV_BOOT) begin
                        NV_BOOT <= 8'(acc_d >> (8 * (32'(nbytes) - 1 - k)));
                    end
                end
            end
        end
    end

endmodule

/* hdl/rad_cpu_end.sv */
/*
 cpu end of the system bus: takes user commands, keeps alignment and the
 byte-only controller space, and refuses plain writes to the nonvolatile bytes.
 assumes the user side is on REF_CLK.
*/
`timescale 1ns/1ps
module rad_cpu_end #(
    parameter logic [7:0] INTC_WRITE_MASK = 8'hff
) (
    input  wire logic        REF_CLK,
    input  wire logic        SYS_RST,
    rad_if.cpu               BUS,
    input  wire logic        CMD_VALID,
    input  wire logic [31:0] CMD_ADDR,
    input  wire logic [1:0]  CMD_SIZE,
    input  wire logic        CMD_WRITE,
    input  wire logic [31:0] CMD_WDATA,
    output logic             CMD_READY,
    output logic             RSP_VALID,
    output logic             RSP_ERR,
    output logic             RSP_LOCAL,
    output logic [31:0]      RSP_RDATA
);

    ////////////////////////////////////////////////////////////////////////////
    // local checks before the bus is touched

    logic misaligned;
    logic intc_wide;
    logic nv_write;
    logic intc_hit;

    assign intc_hit   = CMD_ADDR >= rad_pkg::RAD_INTC_BASE;
    assign misaligned = (CMD_SIZE == rad_pkg::RAD_SZ_WORD && CMD_ADDR[0]) ||
                        (CMD_SIZE == rad_pkg::RAD_SZ_LONG && CMD_ADDR[1:0] != 2'h0);
    assign intc_wide  = intc_hit && CMD_SIZE != rad_pkg::RAD_SZ_BYTE;
    assign nv_write   = CMD_WRITE && CMD_ADDR >= rad_pkg::RAD_NV_FIRST &&
                        CMD_ADDR <= rad_pkg::RAD_NV_SEC;

    ////////////////////////////////////////////////////////////////////////////
    // request and answer; req drops for at least three cycles after every answer

    rad_pkg::rad_state_e state_q;

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state_q   <= rad_pkg::RAD_ST_IDLE;
            CMD_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_ERR   <= 1'b0;
            RSP_LOCAL <= 1'b0;
            RSP_RDATA <= 32'h00000000;
            BUS.req   <= 1'b0;
            BUS.write <= 1'b0;
            BUS.size  <= 2'h0;
            BUS.addr  <= 32'h00000000;
            BUS.wdata <= 32'h00000000;
        end else begin
            RSP_VALID <= 1'b0;
            unique case (state_q)
                rad_pkg::RAD_ST_IDLE: begin
                    CMD_READY <= 1'b1;
                    if (CMD_VALID && CMD_READY) begin
                        CMD_READY <= 1'b0;
                        if (misaligned || intc_wide || nv_write) begin
                            RSP_VALID <= 1'b1;
                            RSP_ERR   <= 1'b1;
                            RSP_LOCAL <= 1'b1;
                            RSP_RDATA <= 32'h00000000;
                            state_q   <= rad_pkg::RAD_ST_RESP;
                        end else begin
                            BUS.req   <= 1'b1;
                            BUS.write <= CMD_WRITE;
                            BUS.size  <= CMD_SIZE;
                            BUS.addr  <= CMD_ADDR;
                            BUS.wdata <= intc_hit ?
                                         {24'h000000, CMD_WDATA[7:0] & INTC_WRITE_MASK} :
                                         CMD_WDATA;
                            state_q   <= rad_pkg::RAD_ST_WAIT;
                        end
                    end
                end
                rad_pkg::RAD_ST_WAIT: begin
                    if (BUS.ack || BUS.err) begin
                        BUS.req   <= 1'b0;
                        RSP_VALID <= 1'b1;
                        RSP_ERR   <= BUS.err;
                        RSP_LOCAL <= 1'b0;
                        RSP_RDATA <= BUS.rdata;
                        state_q   <= rad_pkg::RAD_ST_RESP;
                    end
                end
                rad_pkg::RAD_ST_RESP: state_q <= rad_pkg::RAD_ST_IDLE;
            endcase
        end
    end

endmodule

/* verif/rad_asserts.sv */
/*
 checker for the system bus between the cpu end and the region bridge.
 assumes the bench wires each interface signal to it by name.
*/
`timescale 1ns/1ps
module rad_asserts (
    input wire logic        REF_CLK,
    input wire logic        SYS_RST,
    input wire logic        req,
    input wire logic        write,
    input wire logic [1:0]  size,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        ack,
    input wire logic        err
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////
    property p_flw; $rose(req) && write && addr <= 32'h0000_3fff && size != 2'h2 |=> err; endproperty
    a_flw: assert property (p_flw) else $error("narrow flash write not refused");
    property p_romw; $rose(req) && write && addr[31:12] == 20'h00300 |=> err; endproperty
    a_romw: assert property (p_romw) else $error("rom write not refused");
    property p_p16b;
        $rose(req) && size == 2'h0 && addr >= 32'hffff_ec00 && addr < 32'hffff_ffc0 |=> err;
    endproperty
    a_p16b: assert property (p_p16b) else $error("byte to 16-bit area not refused");
    property p_gap; $rose(req) && addr > 32'h0000_3fff && addr < 32'h0030_0000 |=> err; endproperty
    a_gap: assert property (p_gap) else $error("unimplemented access not refused");
    // ack needs a target beat, so never before the third edge
    property p_ram; $rose(req) && addr[31:11] == 21'h1000 |=> (!err && !ack) [*2] ##[1:40] ack;
    endproperty
    a_ram: assert property (p_ram) else $error("ram access not completed");
    property p_hold; req && !ack && !err |=> req && $stable(addr) && $stable(wdata); endproperty
    a_hold: assert property (p_hold) else $error("request changed before answer");
    property p_one; ack || err |=> !ack && !err && !req; endproperty
    a_one: assert property (p_one) else $error("answer longer than one cycle");
    property p_excl; !(ack && err); endproperty
    a_excl: assert property (p_excl) else $error("ack and error together");
    ////////////////////////////////////////
    c_wr: cover property ($rose(req) && write);
    c_err: cover property (err);
    c_rd: cover property (ack && !write);
endmodule

/* verif/region_access_decoder_bench.sv */
/*
 bench: cpu end and region bridge joined by the bus interface.
 assumes the bench plays both the cpu user and every target region.
*/
`timescale 1ns/1ps
module region_access_decoder_bench;
    localparam logic [7:0] ZM = 8'h81;
    localparam logic [7:0] WM = 8'h7f;
    logic                 ref_clk = 1'b0, sys_rst = 1'b1, ard = 1'b0;
    logic                 cmd_valid = 1'b0, cmd_write = 1'b0, tgt_ack = 1'b0;
    logic [1:0]           cmd_size = 2'h0;
    logic [31:0]          cmd_addr = 32'h0, cmd_wdata = 32'h0, tgt_rdata = 32'h0;
    logic                 tgt_req, tgt_wr, cmd_ready, rsp_valid, rsp_err, rsp_local;
    logic                 ill_rst, adr_exc;
    logic [1:0]           tgt_size;
    logic [7:0]           nv_sec, nv_boot;
    logic [31:0]          tgt_addr, tgt_wdata, rsp_rdata, b_addr[$], b_wd[$];
    logic [1:0]           b_sz[$];
    rad_pkg::rad_region_e tgt_sel, b_sel[$];
    int                   n_errors = 0, tests_run = 0, lat = 0, n_ill = 0, n_exc = 0;
    rad_if bus ();
    rad_bridge #(.INTC_ZERO_MASK(ZM)) i_rad_bridge (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst), .BUS(bus), .ADDRESS_RESET_DISABLE(ard),
        .TGT_REQ(tgt_req), .TGT_SEL(tgt_sel), .TGT_ADDR(tgt_addr), .TGT_SIZE(tgt_size),
        .TGT_WR(tgt_wr), .TGT_WDATA(tgt_wdata), .TGT_ACK(tgt_ack), .TGT_RDATA(tgt_rdata),
        .ILLEGAL_ADDR_RST(ill_rst), .ADDR_ERR_EXC(adr_exc), .NV_SECURITY(nv_sec),
        .NV_BOOT(nv_boot));
    rad_cpu_end #(.INTC_WRITE_MASK(WM)) i_rad_cpu_end (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst), .BUS(bus), .CMD_VALID(cmd_valid),
        .CMD_ADDR(cmd_addr), .CMD_SIZE(cmd_size), .CMD_WRITE(cmd_write), .CMD_WDATA(cmd_wdata),
        .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_ERR(rsp_err),
        .RSP_LOCAL(rsp_local), .RSP_RDATA(rsp_rdata));
    rad_asserts i_rad_asserts (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst), .req(bus.req), .write(bus.write),
        .size(bus.size), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
        .ack(bus.ack), .err(bus.err));
    always #10 ref_clk = ~ref_clk;
    ////////////////////////////////////////
    // each byte is tied to its address, so a beat at a wrong place cannot match
    function automatic logic [31:0] pat(logic [31:0] a, logic [1:0] s);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < (1 << s); i++) v = {v[23:0], a[7:0] + 8'(i) + 8'h10};
        return v;
    endfunction
    always @(posedge ref_clk) begin
        #1;
        while (tgt_req === 1'b1) begin
            b_addr.push_back(tgt_addr);
            b_wd.push_back(tgt_wdata);
            b_sz.push_back(tgt_size);
            b_sel.push_back(tgt_sel);
            repeat (lat + 1) @(posedge ref_clk);
            #1 tgt_ack = 1'b1;
            tgt_rdata = pat(tgt_addr, tgt_size);
            @(posedge ref_clk);
            #1 tgt_ack = 1'b0;
            // released data is inverted so a late capture shows up
            tgt_rdata = ~tgt_rdata;
        end
    end
    always @(posedge ref_clk) begin
        if (ill_rst === 1'b1) n_ill++;
        if (adr_exc === 1'b1) n_exc++;
    end
    ////////////////////////////////////////
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmd(logic [31:0] a, logic [1:0] s, logic w, logic [31:0] d);
        int n;
        n = 0;
        b_addr.delete();
        b_wd.delete();
        b_sz.delete();
        b_sel.delete();
        while (cmd_ready !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1 n++;
        end
        {cmd_addr, cmd_size, cmd_write, cmd_wdata} = {a, s, w, d};
        cmd_valid = 1'b1;
        @(posedge ref_clk);
        #1 cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1 n++;
        end
        if (n >= 300) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic acc(logic [31:0] a, logic [1:0] s, logic w, logic [31:0] d, logic e);
        cmd(a, s, w, d);
        chk("error", 32'(rsp_err), 32'(e));
        if (!e && !w) chk("read data", rsp_rdata, pat(a, s));
    endtask
    task automatic beats(int n, logic [1:0] s);
        int k;
        k = 8 << s;
        chk("beat count", 32'(b_addr.size()), 32'(n));
        chk("beat write", 32'(tgt_wr), 32'(cmd_write));
        for (int i = 0; i < b_addr.size(); i++) begin
            chk("beat addr", b_addr[i], cmd_addr + 32'(i * (1 << s)));
            chk("beat size", 32'(b_sz[i]), 32'(s));
            if (cmd_write) chk("beat data", b_wd[i], 32'(cmd_wdata >> (k * (n - 1 - i))) &
                32'((33'h1 << k) - 33'h1));
        end
    endtask
    ////////////////////////////////////////
    task automatic t_nv();
        chk("boot", 32'(nv_boot), 32'h0000_00ff);
        chk("security", 32'(nv_sec), 32'h0000_00ff);
        cmd(32'h0000_3fff, 2'h0, 1'b1, 32'h0000_0000);
        chk("local", 32'(rsp_local), 32'h1);
        cmd(32'h0000_3ffc, 2'h2, 1'b1, 32'h0000_0000);
        chk("local", 32'(rsp_local), 32'h1);
        acc(32'h0000_3ffc, 2'h2, 1'b0, 32'h0, 1'b0);
        chk("boot", 32'(nv_boot), pat(32'h0000_3ffe, 2'h0));
        chk("security", 32'(nv_sec), pat(32'h0000_3fff, 2'h0));
        $display("test nonvolatile done");
    endtask
    task automatic t_ram();
        lat = 2;
        acc(32'h0080_0001, 2'h0, 1'b1, 32'h0000_005a, 1'b0);
        beats(1, 2'h0);
        acc(32'h0080_0004, 2'h2, 1'b0, 32'h0, 1'b0);
        beats(1, 2'h2);
        cmd(32'h0080_0001, 2'h1, 1'b0, 32'h0);
        chk("local", 32'(rsp_local), 32'h1);
        $display("test ram done");
    endtask
    task automatic t_narrow();
        lat = 0;
        acc(32'hffff_8010, 2'h2, 1'b1, 32'h1122_3344, 1'b0);
        beats(4, 2'h0);
        acc(32'hffff_8020, 2'h2, 1'b0, 32'h0, 1'b0);
        beats(4, 2'h0);
        acc(32'hffff_8022, 2'h1, 1'b1, 32'h0000_a55a, 1'b0);
        beats(2, 2'h0);
        acc(32'hffff_8024, 2'h1, 1'b0, 32'h0, 1'b0);
        beats(2, 2'h0);
        lat = 1;
        acc(32'hffff_ec04, 2'h2, 1'b1, 32'haabb_ccdd, 1'b0);
        beats(2, 2'h1);
        acc(32'hffff_ec00, 2'h2, 1'b0, 32'h0, 1'b0);
        beats(2, 2'h1);
        acc(32'hffff_ec01, 2'h0, 1'b0, 32'h0, 1'b1);
        chk("beat count", 32'(b_addr.size()), 32'h0);
        $display("test narrow buses done");
    endtask
    task automatic t_perm();
        logic [31:0] a [8];
        logic [3:0]  c [8];
        a = '{32'h100, 32'h102, 32'h104, 32'h101, 32'h30_0001, 32'h30_0004, 32'h30_0002,
              32'hc0_0004};
        c = '{4'h3, 4'h7, 4'ha, 4'h0, 4'h3, 4'h8, 4'h7, 4'ha};
        for (int i = 0; i < 8; i++) begin
            acc(a[i], c[i][3:2], c[i][1], 32'h1234_5678, c[i][0]);
            chk("local", 32'(rsp_local), 32'h0);
        end
        acc(32'h00c0_0000, 2'h3, 1'b0, 32'h0, 1'b1);
        chk("local", 32'(rsp_local), 32'h0);
        $display("test permissions done");
    endtask
    task automatic t_map();
        logic [31:0] a [7];
        a = '{32'h0, 32'h30_0000, 32'h80_0000, 32'hc0_0000, 32'hffff_8000, 32'hffff_ec00,
              32'hffff_ffc5};
        for (int i = 0; i < 7; i++) begin
            cmd(a[i], (i == 6) ? 2'h0 : 2'h1, 1'b0, 32'h0);
            chk("region", 32'(b_sel[0]), 32'(rad_pkg::rad_region_e'(i + 1)));
        end
        chk("controller data", rsp_rdata, pat(a[6], 2'h0) & {24'h0, ~ZM});
        cmd(32'hffff_ffc4, 2'h1, 1'b0, 32'h0);
        chk("local", 32'(rsp_local), 32'h1);
        acc(32'hffff_ffc6, 2'h0, 1'b1, 32'h0000_00ff, 1'b0);
        chk("controller write", b_wd[0], {24'h0, WM});
        $display("test map done");
    endtask
    task automatic t_unimpl();
        ard = 1'b0;
        acc(32'h0000_4000, 2'h2, 1'b0, 32'h0, 1'b1);
        ard = 1'b1;
        acc(32'hffff_0000, 2'h0, 1'b1, 32'h0000_0001, 1'b1);
        chk("reset pulses", 32'(n_ill), 32'h1);
        chk("exception pulses", 32'(n_exc), 32'h1);
        chk("beat count", 32'(b_addr.size()), 32'h0);
        $display("test unimplemented done");
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        t_nv();
        t_ram();
        t_narrow();
        t_perm();
        t_map();
        t_unimpl();
        stop_test();
    end
endmodule
